// ---- logic/timer_two_channel.v ----
`include "timer_consts.vh"

// Notes on behaviour
// - Sixteen-bit counter with two sixteen-bit channels.
// - Each channel captures or compares; PWM, intervals.
// - Counter overflow can raise an interrupt request.
// - Each channel raises its own interrupt request.
// - Channel capture inputs: pins, auxiliary (channel 0 only), ground, supply.
module timer_two_channel #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input  wire             ref_clk,
    input  wire             rst,
    // Peripheral register port, byte addressed, word wide.
    input  wire [15:0]      busAddr,
    input  wire             busWrite,
    input  wire             busRead,
    input  wire [15:0]      busWrData,
    output reg  [15:0]      busRdData_reg,
    // Clock sources and capture pins, all asynchronous.
    input  wire             timerExtClockIn,
    input  wire             auxClock,
    input  wire             submainClock,
    input  wire             chan0CaptureInA,
    input  wire             chan1CaptureInA,
    input  wire             chan1CaptureInB,
    // Interrupt requests.
    output reg              overflowIrq_reg,
    output reg              chan0Irq_reg,
    output reg              chan1Irq_reg,
    // Channel output pins.
    output wire             channel0Pin,
    output wire             channel1Pin
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Flag update: software write first, then hardware set, so a set that
    // lands with a clear is never lost.
    function [15:0] flagUpd;
        input [15:0] cur;
        input        wr;
        input [15:0] data;
        input [15:0] rwMask;
        input        clrFlag;
        input        setFlag;
        input        setCov;
        reg   [15:0] tmp;
        begin
            tmp = wr ? ((data & rwMask) | (cur & ~rwMask)) : cur;
            if (clrFlag) tmp[`CC_FLAG] = 1'b0;
            if (setFlag) tmp[`CC_FLAG] = 1'b1;
            if (setCov)  tmp[`CC_COV]  = 1'b1;
            flagUpd = tmp;
        end
    endfunction

    // Four-way selection of an input bit.
    function pick4;
        input [1:0] sel;
        input       a;
        input       b;
        input       c;
        input       d;
        begin
            case (sel)
                2'h0:    pick4 = a;
                2'h1:    pick4 = b;
                2'h2:    pick4 = c;
                default: pick4 = d;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for all outside inputs: two stages, then a third
    // stage only so that edges can be found without touching stage one.
    reg  [5:0] syncA_reg;   // First stage, read only by the second.
    reg  [5:0] syncB_reg;   // Second stage, safe to use.
    reg  [5:0] syncC_reg;   // Delayed copy for edge detection.

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA_reg <= 6'h00;
            syncB_reg <= 6'h00;
            syncC_reg <= 6'h00;
        end else begin
            syncA_reg <= {chan1CaptureInB, chan1CaptureInA, chan0CaptureInA,
                          submainClock, auxClock, timerExtClockIn};
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    reg  [15:0]      ctl_reg;       // Timer control.
    reg  [15:0]      ch0Ctl_reg;    // Channel 0 control.
    reg  [15:0]      ch1Ctl_reg;    // Channel 1 control.
    reg  [WIDTH-1:0] count_reg;     // Counter.
    reg  [WIDTH-1:0] count_next;
    reg              down_reg;      // Up/down mode is heading down.
    reg              down_next;
    reg              ovfEvent;      // Counter wrapped to zero.
    reg  [2:0]       divCnt_reg;    // Input divider.
    reg              step_reg;      // Counter ticked or was written last cycle.
    reg  [15:0]      rdData;

    wire [1:0] mode   = ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO];
    wire [1:0] divSel = ctl_reg[`CTL_DIV_HI:`CTL_DIV_LO];
    wire [2:0] divMask = (3'h1 << divSel) - 3'h1;

    // Clock source edge, after the divider.
    wire srcLevel = pick4(ctl_reg[`CTL_SRC_HI:`CTL_SRC_LO], syncB_reg[0],
                          syncB_reg[1], syncB_reg[2], syncB_reg[0]);
    wire srcPrev  = pick4(ctl_reg[`CTL_SRC_HI:`CTL_SRC_LO], syncC_reg[0],
                          syncC_reg[1], syncC_reg[2], syncC_reg[0]);
    wire srcEdge  = srcLevel & ~srcPrev;
    wire tick     = srcEdge & (divCnt_reg == divMask) &
                    (mode != `MODE_STOP);

    // Capture input selection per channel.
    wire cap0Level = pick4(ch0Ctl_reg[`CC_SEL_HI:`CC_SEL_LO], syncB_reg[3],
                           syncB_reg[1], 1'b0, 1'b1);
    wire cap1Level = pick4(ch1Ctl_reg[`CC_SEL_HI:`CC_SEL_LO], syncB_reg[4],
                           syncB_reg[5], 1'b0, 1'b1);

    // Bus decodes.
    wire wrCtl   = busWrite & (busAddr == `OFS_CTL);
    wire wrCh0C  = busWrite & (busAddr == `OFS_CH0CTL);
    wire wrCh1C  = busWrite & (busAddr == `OFS_CH1CTL);
    wire wrCount = busWrite & (busAddr == `OFS_COUNT);
    wire wrCh0V  = busWrite & (busAddr == `OFS_CH0VAL);
    wire wrCh1V  = busWrite & (busAddr == `OFS_CH1VAL);
    wire rdVec   = busRead  & (busAddr == `OFS_VECTOR);
    wire clearCnt = wrCtl & busWrData[`CTL_CLEAR];

    // Reading the vector clears the source it reports, channel 1 first.
    wire vecCh1  = ch1Ctl_reg[`CC_FLAG];
    wire vecOvf  = ~vecCh1 & ctl_reg[`CTL_OVF_FLAG];

    wire [WIDTH-1:0] ch0Value;
    wire [WIDTH-1:0] ch1Value;
    wire             ch0Event;
    wire             ch1Event;
    wire             ch0Equal;

    ////////////////////////////////////////////////////////////////////////
    // Counter next state for each mode.
    always @* begin
        count_next = count_reg;
        down_next  = down_reg;
        ovfEvent   = 1'b0;
        if (clearCnt) begin
            count_next = `COUNT_ZERO;
            down_next  = 1'b0;
        end else if (wrCount) begin
            count_next = busWrData;
        end else if (tick) begin
            case (mode)
                `MODE_UP: begin
                    // Period set by channel 0; wrap counts as overflow.
                    if (count_reg >= ch0Value) begin
                        count_next = `COUNT_ZERO;
                        ovfEvent   = 1'b1;
                    end else begin
                        count_next = count_reg + `COUNT_ONE;
                    end
                end
                `MODE_CONT: begin
                    if (count_reg == `COUNT_MAX) begin
                        count_next = `COUNT_ZERO;
                        ovfEvent   = 1'b1;
                    end else begin
                        count_next = count_reg + `COUNT_ONE;
                    end
                end
                `MODE_UPDN: begin
                    if (!down_reg) begin
                        if (count_reg >= ch0Value) begin
                            down_next  = 1'b1;
                            count_next = (count_reg == `COUNT_ZERO) ?
                                         `COUNT_ZERO :
                                         count_reg - `COUNT_ONE;
                        end else begin
                            count_next = count_reg + `COUNT_ONE;
                        end
                    end else if (count_reg <= `COUNT_ONE) begin
                        // Reaching zero on the way down ends the period.
                        count_next = `COUNT_ZERO;
                        down_next  = 1'b0;
                        ovfEvent   = 1'b1;
                    end else begin
                        count_next = count_reg - `COUNT_ONE;
                    end
                end
                default: count_next = count_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux; the live input level shows in each channel control.
    always @* begin
        case (busAddr)
            `OFS_VECTOR: rdData = vecCh1 ? `VEC_CH1 :
                                  (vecOvf ? `VEC_OVF : `VEC_NONE);
            `OFS_CTL:    rdData = ctl_reg;
            `OFS_CH0CTL: rdData = {ch0Ctl_reg[15:4], cap0Level,
                                   ch0Ctl_reg[2:0]};
            `OFS_CH1CTL: rdData = {ch1Ctl_reg[15:4], cap1Level,
                                   ch1Ctl_reg[2:0]};
            `OFS_COUNT:  rdData = count_reg;
            `OFS_CH0VAL: rdData = ch0Value;
            `OFS_CH1VAL: rdData = ch1Value;
            default:     rdData = `COUNT_ZERO;
        endcase
    end

    // Next values of the control registers, used for the irq outputs too.
    wire [15:0] ctlNext = flagUpd(ctl_reg, wrCtl, busWrData, `CTL_RW_MASK,
                                  rdVec & vecOvf, ovfEvent, 1'b0);
    wire [15:0] ch0Next = flagUpd(ch0Ctl_reg, wrCh0C, busWrData,
                                  `CC_RW_MASK, 1'b0, ch0Event,
                                  ch0Event & ch0Ctl_reg[`CC_CAPTURE] &
                                  ch0Ctl_reg[`CC_FLAG]);
    wire [15:0] ch1Next = flagUpd(ch1Ctl_reg, wrCh1C, busWrData,
                                  `CC_RW_MASK, rdVec & vecCh1, ch1Event,
                                  ch1Event & ch1Ctl_reg[`CC_CAPTURE] &
                                  ch1Ctl_reg[`CC_FLAG]);

    ////////////////////////////////////////////////////////////////////////
    // State registers and registered outputs.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_reg         <= `CTL_RESET;
            ch0Ctl_reg      <= `CC_RESET;
            ch1Ctl_reg      <= `CC_RESET;
            count_reg       <= `COUNT_ZERO;
            down_reg        <= 1'b0;
            divCnt_reg      <= 3'h0;
            step_reg        <= 1'b0;
            busRdData_reg   <= `COUNT_ZERO;
            overflowIrq_reg <= 1'b0;
            chan0Irq_reg    <= 1'b0;
            chan1Irq_reg    <= 1'b0;
        end else begin
            ctl_reg    <= ctlNext;
            ch0Ctl_reg <= ch0Next;
            ch1Ctl_reg <= ch1Next;
            count_reg  <= count_next;
            down_reg   <= down_next;
            step_reg   <= tick | wrCount;
            // The divider restarts on clear so the first period is whole.
            if (clearCnt || tick) begin
                divCnt_reg <= 3'h0;
            end else if (srcEdge) begin
                divCnt_reg <= divCnt_reg + 3'h1;
            end
            busRdData_reg   <= busRead ? rdData : `COUNT_ZERO;
            overflowIrq_reg <= ctlNext[`CTL_OVF_FLAG] &
                               ctlNext[`CTL_OVF_IE];
            chan0Irq_reg    <= ch0Next[`CC_FLAG] & ch0Next[`CC_IE];
            chan1Irq_reg    <= ch1Next[`CC_FLAG] & ch1Next[`CC_IE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The two channels.
    cc_channel #(.WIDTH(WIDTH)) channel0Unit (
        .refClk      (ref_clk),
        .rst         (rst),
        .countValue  (count_reg),
        .countStep   (step_reg),
        .periodHit   (ch0Equal),
        .captureMode (ch0Ctl_reg[`CC_CAPTURE]),
        .captureEdge (ch0Ctl_reg[`CC_EDGE_HI:`CC_EDGE_LO]),
        .outMode     (ch0Ctl_reg[`CC_OMODE_HI:`CC_OMODE_LO]),
        .outBit      (ch0Ctl_reg[`CC_OUTBIT]),
        .captureLevel(cap0Level),
        .wrValue     (wrCh0V),
        .wrData      (busWrData),
        .value_reg   (ch0Value),
        .event_reg   (ch0Event),
        .pin_reg     (channel0Pin),
        .equalHit    (ch0Equal)
    );

    cc_channel #(.WIDTH(WIDTH)) channel1Unit (
        .refClk      (ref_clk),
        .rst         (rst),
        .countValue  (count_reg),
        .countStep   (step_reg),
        .periodHit   (ch0Equal),
        .captureMode (ch1Ctl_reg[`CC_CAPTURE]),
        .captureEdge (ch1Ctl_reg[`CC_EDGE_HI:`CC_EDGE_LO]),
        .outMode     (ch1Ctl_reg[`CC_OMODE_HI:`CC_OMODE_LO]),
        .outBit      (ch1Ctl_reg[`CC_OUTBIT]),
        .captureLevel(cap1Level),
        .wrValue     (wrCh1V),
        .wrData      (busWrData),
        .value_reg   (ch1Value),
        .event_reg   (ch1Event),
        .pin_reg     (channel1Pin),
        .equalHit    ()
    );

endmodule

// ---- logic/timer_consts.vh ----
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register byte addresses on the word-wide peripheral bus.
`define OFS_VECTOR    16'h012e
`define OFS_CTL       16'h0160
`define OFS_CH0CTL    16'h0162
`define OFS_CH1CTL    16'h0164
`define OFS_COUNT     16'h0170
`define OFS_CH0VAL    16'h0172
`define OFS_CH1VAL    16'h0174

// Timer control fields.
`define CTL_SRC_HI    9
`define CTL_SRC_LO    8
`define CTL_DIV_HI    7
`define CTL_DIV_LO    6
`define CTL_MODE_HI   5
`define CTL_MODE_LO   4
`define CTL_CLEAR     2
`define CTL_OVF_IE    1
`define CTL_OVF_FLAG  0
`define CTL_RW_MASK   16'h03f3
`define CTL_RESET     16'h0000

// Counting modes.
`define MODE_STOP     2'h0
`define MODE_UP       2'h1
`define MODE_CONT     2'h2
`define MODE_UPDN     2'h3

// Clock source and capture input selections.
`define SEL_A         2'h0
`define SEL_B         2'h1
`define SEL_GND       2'h2
`define SEL_VCC       2'h3
`define SRC_EXT       2'h0
`define SRC_AUX       2'h1
`define SRC_SUBMAIN   2'h2
`define SRC_EXT2      2'h3

// Channel control fields.
`define CC_EDGE_HI    15
`define CC_EDGE_LO    14
`define CC_SEL_HI     13
`define CC_SEL_LO     12
`define CC_CAPTURE    8
`define CC_OMODE_HI   7
`define CC_OMODE_LO   5
`define CC_IE         4
`define CC_IN         3
`define CC_OUTBIT     2
`define CC_COV        1
`define CC_FLAG       0
`define CC_RW_MASK    16'hf1f7
`define CC_RESET      16'h0000

// Capture edge choices.
`define EDGE_NONE     2'h0
`define EDGE_RISE     2'h1
`define EDGE_FALL     2'h2
`define EDGE_BOTH     2'h3

// Output modes.
`define OM_BIT        3'h0
`define OM_SET        3'h1
`define OM_TGL_RST    3'h2
`define OM_SET_RST    3'h3
`define OM_TOGGLE     3'h4
`define OM_RESET      3'h5
`define OM_TGL_SET    3'h6
`define OM_RST_SET    3'h7

// Vector codes and counter limits.
`define VEC_NONE      16'h0000
`define VEC_CH1       16'h0002
`define VEC_OVF       16'h000a
`define COUNT_ZERO    16'h0000
`define COUNT_ONE     16'h0001
`define COUNT_MAX     16'hffff

`endif

// ---- logic/cc_channel.v ----
`include "timer_consts.vh"

// One capture/compare channel: holds a value, captures the counter on a
// chosen edge of its input, or compares against it and drives a pin.
module cc_channel #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input  wire             refClk,
    input  wire             rst,
    // Counter side.
    input  wire [WIDTH-1:0] countValue,
    input  wire             countStep,
    input  wire             periodHit,
    // Configuration from the channel control register, and the selected input level.
    input  wire             captureMode,
    input  wire [1:0]       captureEdge,
    input  wire [2:0]       outMode,
    input  wire             outBit,
    input  wire             captureLevel,
    // Software write of the stored value.
    input  wire             wrValue,
    input  wire [WIDTH-1:0] wrData,
    // Results.
    output reg  [WIDTH-1:0] value_reg,
    output reg              event_reg,
    output reg              pin_reg,
    output wire             equalHit
);

    reg levelPrev_reg;  // Previous captured-input level for edge finding.
    wire rise;
    wire fall;
    wire capHit;

    assign rise     = captureLevel & ~levelPrev_reg;
    assign fall     = ~captureLevel & levelPrev_reg;
    assign capHit   = captureMode &
                      ((captureEdge[0] & rise) | (captureEdge[1] & fall));
    // Equality is judged only on the cycle after the counter moved, so one
    // counter value yields exactly one event however long it stands.
    assign equalHit = countStep & (countValue == value_reg);

    ////////////////////////////////////////////////////////////////////////
    // Value, event and pin registers.
    always @(posedge refClk or posedge rst) begin
        if (rst) begin
            value_reg     <= `COUNT_ZERO;
            event_reg     <= 1'b0;
            pin_reg       <= 1'b0;
            levelPrev_reg <= 1'b0;
        end else begin
            levelPrev_reg <= captureLevel;
            // A capture wins over a software write in the same cycle.
            if (capHit) begin
                value_reg <= countValue;
            end else if (wrValue) begin
                value_reg <= wrData;
            end
            event_reg <= captureMode ? capHit : equalHit;
            // Output unit: compare match first, period match second.
            if (captureMode || outMode == `OM_BIT) begin
                pin_reg <= outBit;
            end else if (equalHit) begin
                case (outMode)
                    `OM_SET, `OM_SET_RST, `OM_RST_SET: pin_reg <= 1'b1;
                    `OM_RESET, `OM_TGL_RST, `OM_TGL_SET: begin
                        pin_reg <= (outMode == `OM_RESET) ? 1'b0 : ~pin_reg;
                    end
                    `OM_TOGGLE: pin_reg <= ~pin_reg;
                    default:    pin_reg <= outBit;
                endcase
            end else if (periodHit) begin
                // PWM modes flip back at the end of the period.
                case (outMode)
                    `OM_TGL_RST, `OM_SET_RST: pin_reg <= 1'b0;
                    `OM_TGL_SET:              pin_reg <= 1'b1;
                    `OM_RST_SET:              pin_reg <= 1'b0;
                    default:                  pin_reg <= pin_reg;
                endcase
            end
        end
    end

endmodule

// ---- verif/timer_two_channel_chk.sv ----
`include "timer_consts.vh"

// Watches the register port and interrupt levels.
module timer_two_channel_chk (
    // Clock and reset.
    input logic        ref_clk,
    input logic        rst,
    // Register port.
    input logic [15:0] busAddr,
    input logic        busWrite,
    input logic        busRead,
    input logic [15:0] busWrData,
    input logic [15:0] busRdData_reg,
    // Interrupt requests.
    input logic        overflowIrq_reg,
    input logic        chan0Irq_reg,
    input logic        chan1Irq_reg
);
    timeunit 1ns;
    timeprecision 1ns;

    // One clock domain: clocking and reset are declared once.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Idle cycles show zero read data.
    a_rdata_idle_zero: assert property (
        !$past(busRead) |-> busRdData_reg == 16'h0000)
        else $error("idle read data not zero");
    // Unmapped places answer zero.
    a_unmapped_reads_zero: assert property (
        busRead && !(busAddr inside {`OFS_VECTOR, `OFS_CTL, `OFS_CH0CTL,
        `OFS_CH1CTL, `OFS_COUNT, `OFS_CH0VAL, `OFS_CH1VAL})
        |=> busRdData_reg == 16'h0000)
        else $error("unmapped read not zero");
    // Reserved and write-only control bits read as zero.
    a_ctl_reserved_zero: assert property (
        busRead && busAddr == `OFS_CTL
        |=> (busRdData_reg & ~`CTL_RW_MASK) == 16'h0000)
        else $error("control reserved bits set");
    // Channel control reserved bits read zero; bit 3 is the input.
    a_cc_reserved_zero: assert property (
        busRead && (busAddr == `OFS_CH0CTL || busAddr == `OFS_CH1CTL)
        |=> (busRdData_reg & ~(`CC_RW_MASK | 16'h0008)) == 16'h0000)
        else $error("channel control reserved bits set");
    // The vector only ever reports one of three codes.
    a_vector_codes_legal: assert property (
        busRead && busAddr == `OFS_VECTOR |=> busRdData_reg inside
        {`VEC_NONE, `VEC_CH1, `VEC_OVF})
        else $error("illegal vector code");
    // The channel 1 stored value reads back as written.
    a_value_readback: assert property (
        busRead && !busWrite && busAddr == `OFS_CH1VAL && !$past(busWrite)
        && $past(busWrite, 2) && $past(busAddr, 2) == `OFS_CH1VAL
        |=> busRdData_reg == $past(busWrData, 3))
        else $error("channel value readback wrong");
    // Overflow enable off drops the request.
    a_ovf_enable_gates: assert property (
        busWrite && busAddr == `OFS_CTL && !busWrData[`CTL_OVF_IE]
        |-> ##2 !overflowIrq_reg)
        else $error("overflow request without enable");
    // Channel 0 enable off drops the request.
    a_ch0_enable_gates: assert property (
        busWrite && busAddr == `OFS_CH0CTL && !busWrData[`CC_IE]
        |-> ##2 !chan0Irq_reg)
        else $error("channel 0 request without enable");
    // Reading the channel 1 code clears its request.
    a_vector_read_clears: assert property (
        busRead && busAddr == `OFS_VECTOR ##1 busRdData_reg == `VEC_CH1
        |-> ##[1:2] !chan1Irq_reg)
        else $error("channel 1 not cleared");
endmodule

bind timer_two_channel timer_two_channel_chk chk_u (
    .ref_clk(ref_clk), .rst(rst), .busAddr(busAddr),
    .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
    .busRdData_reg(busRdData_reg), .overflowIrq_reg(overflowIrq_reg),
    .chan0Irq_reg(chan0Irq_reg), .chan1Irq_reg(chan1Irq_reg)
);

// ---- verif/timer_two_channel_tb.sv ----
`include "timer_consts.vh"

// Drives the timer's ports directly.
module timer_two_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;         // 100 MHz system clock.
    logic        rst = 1'b1;             // Held for five cycles.
    logic [15:0] busAddr = 16'h0000;     // Register address.
    logic        busWrite = 1'b0;        // Write strobe.
    logic        busRead = 1'b0;         // Read strobe.
    logic [15:0] busWrData = 16'h0000;   // Write data.
    logic        timerExtClockIn = 1'b0; // External clock source.
    logic        auxClock = 1'b0;        // Auxiliary clock source.
    logic        submainClock = 1'b0;    // Sub-main clock source.
    logic        chan0CaptureInA = 1'b0; // Channel 0 capture pin.
    logic        chan1CaptureInA = 1'b0; // Channel 1 pin A.
    logic        chan1CaptureInB = 1'b0; // Channel 1 pin B.
    wire  [15:0] busRdData_reg;
    wire         overflowIrq_reg;
    wire         chan0Irq_reg;
    wire         chan1Irq_reg;
    wire         channel0Pin;
    wire         channel1Pin;
    int          num_errors = 0;         // Mismatches seen.
    int          comparisons = 0;        // Comparisons made.
    logic [15:0] regMap [7] = '{`OFS_VECTOR, `OFS_CTL, `OFS_CH0CTL,
        `OFS_CH1CTL, `OFS_COUNT, `OFS_CH0VAL, `OFS_CH1VAL};

    always #5 ref_clk = ~ref_clk;

    timer_two_channel dut_u (
        .ref_clk(ref_clk), .rst(rst), .busAddr(busAddr),
        .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
        .busRdData_reg(busRdData_reg), .timerExtClockIn(timerExtClockIn),
        .auxClock(auxClock), .submainClock(submainClock),
        .chan0CaptureInA(chan0CaptureInA),
        .chan1CaptureInA(chan1CaptureInA),
        .chan1CaptureInB(chan1CaptureInB),
        .overflowIrq_reg(overflowIrq_reg), .chan0Irq_reg(chan0Irq_reg),
        .chan1Irq_reg(chan1Irq_reg), .channel0Pin(channel0Pin),
        .channel1Pin(channel1Pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compares one result.
    task automatic check(input logic [15:0] act, exp);
        comparisons++;
        if (act !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    // One write, strobe high for one edge.
    task automatic wr(input logic [15:0] a, d);
        @(posedge ref_clk);
        busAddr <= a;
        busWrData <= d;
        busWrite <= 1'b1;
        @(posedge ref_clk);
        busWrite <= 1'b0;
    endtask

    // One read; data stand one cycle after the strobe.
    task automatic rdchk(input logic [15:0] a, exp);
        @(posedge ref_clk);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge ref_clk);
        busRead <= 1'b0;
        #1 check(busRdData_reg, exp);
    endtask

    // Lets synchronisers and outputs settle.
    task automatic settle();
        repeat (4) @(posedge ref_clk);
    endtask

    // One slow edge on a clock source, wide enough to sync.
    task automatic pulse(input int s);
        @(posedge ref_clk);
        case (s)
            1: auxClock <= 1'b1;
            2: submainClock <= 1'b1;
            default: timerExtClockIn <= 1'b1;
        endcase
        repeat (3) @(posedge ref_clk);
        auxClock <= 1'b0;
        submainClock <= 1'b0;
        timerExtClockIn <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // Prints counts and verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The run needs about five hundred cycles; this cuts a hang.
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    // Register accesses with worked-out expectations.
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdchk(regMap[i], 16'h0000);
        end
        rdchk(16'h0166, 16'h0000);
        wr(`OFS_CH0VAL, 16'ha5c3);
        rdchk(`OFS_CH0VAL, 16'ha5c3);
        wr(`OFS_CH1VAL, 16'h0777);
        rdchk(`OFS_CH1VAL, 16'h0777);
        // Flag and enable set: the overflow request rises.
        wr(`OFS_CTL, 16'hffff);
        rdchk(`OFS_CTL, `CTL_RW_MASK);
        settle();
        check(16'(overflowIrq_reg), 16'h1);
        wr(`OFS_CTL, 16'h0000);
        settle();
        check(16'(overflowIrq_reg), 16'h0);
        // Supply and ground show in the live level bit.
        wr(`OFS_CH1CTL, 16'h30e4);
        settle();
        rdchk(`OFS_CH1CTL, 16'h30ec);
        wr(`OFS_CH1CTL, 16'h2004);
        settle();
        rdchk(`OFS_CH1CTL, 16'h2004);
        check(16'(channel1Pin), 16'h1);
        @(posedge ref_clk);
        auxClock <= 1'b1;
        wr(`OFS_CH0CTL, 16'h1004);
        settle();
        rdchk(`OFS_CH0CTL, 16'h100c);
        check(16'(channel0Pin), 16'h1);
        @(posedge ref_clk);
        auxClock <= 1'b0;
        wr(`OFS_CH0CTL, 16'h0000);
        wr(`OFS_CH1CTL, 16'h0000);
        // Each source counts alone; a pulse on one other source is ignored.
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_COUNT, 16'h0000);
            wr(`OFS_CTL, (16'(s) << 8) | 16'h0020);
            repeat (3) pulse(s);
            pulse((s + 2) % 4);
            settle();
            rdchk(`OFS_COUNT, 16'h0003);
        end
        // Capture on a rising pin edge, counter stopped.
        wr(`OFS_CTL, 16'h0000);
        wr(`OFS_COUNT, 16'h1234);
        wr(`OFS_CH0CTL, 16'h4100);
        @(posedge ref_clk);
        chan0CaptureInA <= 1'b1;
        settle();
        rdchk(`OFS_CH0VAL, 16'h1234);
        rdchk(`OFS_CH0CTL, 16'h4109);
        // Compare events raise separate requests.
        wr(`OFS_CH0CTL, 16'h0010);
        wr(`OFS_CH0VAL, 16'h0005);
        wr(`OFS_CH1VAL, 16'h0007);
        wr(`OFS_CH1CTL, 16'h0010);
        wr(`OFS_COUNT, 16'h0000);
        wr(`OFS_CTL, 16'h0220);
        repeat (5) pulse(2);
        settle();
        check(16'(chan0Irq_reg), 16'h1);
        check(16'(chan1Irq_reg), 16'h0);
        repeat (2) pulse(2);
        settle();
        check(16'(chan1Irq_reg), 16'h1);
        rdchk(`OFS_VECTOR, `VEC_CH1);
        settle();
        check(16'(chan1Irq_reg), 16'h0);
        rdchk(`OFS_VECTOR, `VEC_NONE);
        // Full 16-bit wrap in continuous mode sets the overflow.
        wr(`OFS_COUNT, `COUNT_MAX);
        wr(`OFS_CTL, 16'h0222);
        pulse(2);
        settle();
        check(16'(overflowIrq_reg), 16'h1);
        rdchk(`OFS_COUNT, `COUNT_ZERO);
        rdchk(`OFS_VECTOR, `VEC_OVF);
        settle();
        check(16'(overflowIrq_reg), 16'h0);
        // Up mode wraps on the tick past the channel 0 value.
        wr(`OFS_CH0VAL, 16'h0003);
        wr(`OFS_COUNT, 16'h0000);
        wr(`OFS_CTL, 16'h0212);
        repeat (4) pulse(2);
        settle();
        rdchk(`OFS_COUNT, `COUNT_ZERO);
        rdchk(`OFS_VECTOR, `VEC_OVF);
        wr(`OFS_CTL, 16'h0272);
        repeat (12) pulse(2);
        rdchk(`OFS_VECTOR, `VEC_OVF);
        print_verdict();
    end
endmodule
